// ---- muting_defs.vh ----
`ifndef MUTING_DEFS_VH
`define MUTING_DEFS_VH

// register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_PAIR_A_SKEW 8'h04
`define OFS_PAIR_B_SKEW 8'h08
`define OFS_DURATION 8'h0C
`define OFS_STATUS 8'h10
`define OFS_INPUTS 8'h14

// field positions
`define CTRL_ACTIVATE_BIT 0
`define STAT_MUTING_BIT 16
`define STAT_RELEASE_BIT 17
`define STAT_ERROR_BIT 18
`define STAT_READY_BIT 19

// reset values, limits held in milliseconds
`define RST_CONTROL 32'h00000000
`define RST_PAIR_A_SKEW 32'h000003E8
`define RST_PAIR_B_SKEW 32'h000003E8
`define RST_DURATION 32'h0000EA60

// timing
`define CLK_PERIOD_NS 40
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define SKEW_MAX_S 4
`define DURATION_MAX_MIN 10
`define SKEW_MAX_MS (`SKEW_MAX_S * 1000)
`define DURATION_MAX_MS (`DURATION_MAX_MIN * 60 * 1000)

// diagnostic codes
`define DIAG_IDLE 16'h0000
`define DIAG_FREE 16'h8000
`define DIAG_INIT 16'h8001
`define DIAG_WAIT_RESET 16'h8003
`define DIAG_RESET_INIT 16'hC001
`define DIAG_RESET_WAIT 16'hC002
`define DIAG_LAMP 16'hC003
`define DIAG_PARAM 16'hC005
`define DIAG_DURATION 16'hC006
`define DIAG_SKEW_A 16'hC007
`define DIAG_SKEW_B 16'hC008
`define DIAG_SEQ_HIGH 4'hC
`define DIAG_SEQ_LOW 4'h4
`define SEQ_NO_PERMIT 4'hF

// sequence state codes, index 1 to C
`define DIAG_F_A1 16'h8011
`define DIAG_F_A2 16'h8311
`define DIAG_F_AB 16'h8012
`define DIAG_F_B1 16'h8014
`define DIAG_F_B2 16'h8314
`define DIAG_F_OUT 16'h8021
`define DIAG_B_B1 16'h8122
`define DIAG_B_B2 16'h8422
`define DIAG_B_BA 16'h8121
`define DIAG_B_A1 16'h8114
`define DIAG_B_A2 16'h8414
`define DIAG_B_OUT 16'h8112

`endif

// ---- input_sampler.v ----
`timescale 1ns/1ns
`default_nettype none

module input_sampler #(
  parameter W = 4
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [W-1:0] d,
  output reg [W-1:0] level,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);
  reg [W-1:0] prev_reg;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level <= {W{1'b0}};
      prev_reg <= {W{1'b0}};
    end
    else if (ce)
    begin
      level <= d;
      prev_reg <= level;
    end
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;
endmodule // input_sampler

`default_nettype wire

// ---- ms_timer.v ----
`timescale 1ns/1ns
`default_nettype none

module ms_timer (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire tick,
  input wire run,
  input wire [19:0] limit,
  output wire over
);
  reg [20:0] count_reg;

  // saturates so a stuck run cannot wrap back under the limit
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= 21'h000000;
    else if (ce)
    begin
      if (!run)
        count_reg <= 21'h000000;
      else if (tick && !count_reg[20])
        count_reg <= count_reg + 21'h000001;
    end
  end

  assign over = run && (count_reg > {1'b0, limit});
endmodule // ms_timer

`default_nettype wire

// ---- parallel_muting_error_handler.v ----
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "muting_defs.vh"

module parallel_muting_error_handler #(
  parameter MS_CYCLES = `MS_CYCLES
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire pair_a_first_sensor,
  input wire pair_a_second_sensor,
  input wire pair_b_first_sensor,
  input wire pair_b_second_sensor,
  input wire muting_permit,
  input wire lamp_health_in,
  input wire reset_in,
  output reg ready,
  output reg error,
  output reg guarded_release_out,
  output reg muting_active_out,
  output reg [15:0] diagnostic_code
);
  localparam ST_IDLE = 3'd0;
  localparam ST_INIT = 3'd1;
  localparam ST_WAIT = 3'd2;
  localparam ST_RUN = 3'd3;
  localparam ST_ERR = 3'd4;

  reg sync1_reg;
  reg rst_n;
  reg [31:0] control_reg;
  reg [31:0] pair_a_skew_limit;
  reg [31:0] pair_b_skew_limit;
  reg [31:0] muting_duration_limit;
  reg [14:0] prescale_reg;
  reg tick_reg;
  reg [2:0] st_reg;
  reg [2:0] st_next;
  reg [3:0] idx_reg;
  reg [3:0] idx_next;
  reg [15:0] code_next;
  reg entry_reg;
  reg entry_next;
  reg [3:0] nidx;
  reg seq_bad;
  reg [3:0] bad_idx;

  wire [6:0] lvl;
  wire [6:0] rise;
  wire [6:0] fall;
  wire sensor_a1_level = lvl[0];
  wire sensor_a2_level = lvl[1];
  wire sensor_b1_level = lvl[2];
  wire sensor_b2_level = lvl[3];
  wire permit = lvl[4];
  wire lamp_ok = lvl[5];
  wire rst_lvl = lvl[6];
  wire ra1 = rise[0];
  wire ra2 = rise[1];
  wire rb1 = rise[2];
  wire rb2 = rise[3];
  wire rst_rise = rise[6];
  wire any_rise = |rise[3:0];
  wire any_a = sensor_a1_level | sensor_a2_level;
  wire any_b = sensor_b1_level | sensor_b2_level;
  wire all4 = sensor_a1_level & sensor_a2_level & sensor_b1_level & sensor_b2_level;
  wire activate = control_reg[`CTRL_ACTIVATE_BIT];
  wire over_dur;
  wire over_a;
  wire over_b;
  wire apb_access = psel && penable && !pready;
  wire wr = apb_access && pwrite;

  // reset released through two flops
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      sync1_reg <= 1'b1;
      rst_n <= sync1_reg;
    end
  end

  input_sampler #(.W(7)) u_sampler (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d({reset_in, lamp_health_in, muting_permit, pair_b_second_sensor,
        pair_b_first_sensor, pair_a_second_sensor, pair_a_first_sensor}),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  // parameter range checks, negative shows as the sign bit
  wire skew_a_bad = pair_a_skew_limit[31] || (pair_a_skew_limit > `SKEW_MAX_MS);
  wire skew_b_bad = pair_b_skew_limit[31] || (pair_b_skew_limit > `SKEW_MAX_MS);
  wire dur_bad = muting_duration_limit[31] ||
    (muting_duration_limit > `DURATION_MAX_MS);
  wire param_bad = skew_a_bad || skew_b_bad || dur_bad;

  // millisecond tick for the timers
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prescale_reg <= 15'h0000;
      tick_reg <= 1'b0;
    end
    else if (ce)
    begin
      tick_reg <= (prescale_reg == MS_CYCLES[14:0] - 15'h0001);
      if (prescale_reg == MS_CYCLES[14:0] - 15'h0001)
        prescale_reg <= 15'h0000;
      else
        prescale_reg <= prescale_reg + 15'h0001;
    end
  end

  wire running = (st_reg == ST_RUN);
  wire mut_now = running && (idx_reg != 4'h0);
  wire run_a = running && (idx_reg == 4'h1 || idx_reg == 4'h2 ||
    idx_reg == 4'hA || idx_reg == 4'hB);
  wire run_b = running && (idx_reg == 4'h4 || idx_reg == 4'h5 ||
    idx_reg == 4'h7 || idx_reg == 4'h8);

  ms_timer u_dur (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick_reg),
    .run(mut_now),
    .limit(muting_duration_limit[19:0]),
    .over(over_dur)
  );

  ms_timer u_skew_a (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick_reg),
    .run(run_a),
    .limit(pair_a_skew_limit[19:0]),
    .over(over_a)
  );

  ms_timer u_skew_b (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick_reg),
    .run(run_b),
    .limit(pair_b_skew_limit[19:0]),
    .over(over_b)
  );

  function [15:0] state_code;
    input [3:0] i;
    begin
      case (i)
        4'h1: state_code = `DIAG_F_A1;
        4'h2: state_code = `DIAG_F_A2;
        4'h3: state_code = `DIAG_F_AB;
        4'h4: state_code = `DIAG_F_B1;
        4'h5: state_code = `DIAG_F_B2;
        4'h6: state_code = `DIAG_F_OUT;
        4'h7: state_code = `DIAG_B_B1;
        4'h8: state_code = `DIAG_B_B2;
        4'h9: state_code = `DIAG_B_BA;
        4'hA: state_code = `DIAG_B_A1;
        4'hB: state_code = `DIAG_B_A2;
        4'hC: state_code = `DIAG_B_OUT;
        default: state_code = `DIAG_FREE;
      endcase
    end
  endfunction

  // sequence supervision: next index and illegal-order check
  always @*
  begin
    nidx = idx_reg;
    seq_bad = 1'b0;
    bad_idx = idx_reg;
    case (idx_reg)
      4'h0:
      begin
        if (any_rise && !permit)
        begin
          seq_bad = 1'b1;
          bad_idx = `SEQ_NO_PERMIT;
        end
        else if ((any_a && any_b) ||
          (ra1 && sensor_a2_level && !ra2) || (ra2 && sensor_a1_level && !ra1) ||
          (rb1 && sensor_b2_level && !rb2) || (rb2 && sensor_b1_level && !rb1) ||
          (sensor_a1_level && !ra1 && sensor_a2_level && !ra2) ||
          (sensor_b1_level && !rb1 && sensor_b2_level && !rb2))
          seq_bad = 1'b1;
        else if (ra1 && ra2)
          nidx = 4'h3;
        else if (ra1)
          nidx = 4'h1;
        else if (ra2)
          nidx = 4'h2;
        else if (rb1 && rb2)
          nidx = 4'h9;
        else if (rb1)
          nidx = 4'h7;
        else if (rb2)
          nidx = 4'h8;
      end
      4'h1:
        if (!permit || !sensor_a1_level || any_b)
          seq_bad = 1'b1;
        else if (sensor_a2_level)
          nidx = 4'h3;
      4'h2:
        if (!permit || !sensor_a2_level || any_b)
          seq_bad = 1'b1;
        else if (sensor_a1_level)
          nidx = 4'h3;
      4'h3:
        if (!sensor_a1_level || !sensor_a2_level)
          seq_bad = 1'b1;
        else if (all4)
          nidx = 4'h6;
        else if (rb1 && !sensor_b2_level)
          nidx = 4'h4;
        else if (rb2 && !sensor_b1_level)
          nidx = 4'h5;
      4'h4:
        if (!sensor_a1_level || !sensor_a2_level || !sensor_b1_level)
          seq_bad = 1'b1;
        else if (sensor_b2_level)
          nidx = 4'h6;
      4'h5:
        if (!sensor_a1_level || !sensor_a2_level || !sensor_b2_level)
          seq_bad = 1'b1;
        else if (sensor_b1_level)
          nidx = 4'h6;
      4'h6:
        if (any_rise)
          seq_bad = 1'b1;
        else if (!any_a && (fall[2] || fall[3]))
          nidx = 4'h0;
      4'h7:
        if (!permit || any_a || !sensor_b1_level)
          seq_bad = 1'b1;
        else if (sensor_b2_level)
          nidx = 4'h9;
      4'h8:
        if (!permit || any_a || !sensor_b2_level)
          seq_bad = 1'b1;
        else if (sensor_b1_level)
          nidx = 4'h9;
      4'h9:
        if (!sensor_b1_level || !sensor_b2_level)
          seq_bad = 1'b1;
        else if (all4)
          nidx = 4'hC;
        else if (ra1 && !sensor_a2_level)
          nidx = 4'hA;
        else if (ra2 && !sensor_a1_level)
          nidx = 4'hB;
      4'hA:
        if (!sensor_b1_level || !sensor_b2_level || !sensor_a1_level)
          seq_bad = 1'b1;
        else if (sensor_a2_level)
          nidx = 4'hC;
      4'hB:
        if (!sensor_b1_level || !sensor_b2_level || !sensor_a2_level)
          seq_bad = 1'b1;
        else if (sensor_a1_level)
          nidx = 4'hC;
      4'hC:
        if (any_rise)
          seq_bad = 1'b1;
        else if (!any_b && (fall[0] || fall[1]))
          nidx = 4'h0;
      default:
        seq_bad = 1'b1;
    endcase
  end

  // a latched error leaves for wait only once every cause is gone; clearing activate sends it to idle at once
  wire cause_clear = !param_bad && lamp_ok && !any_a && !any_b && !rst_lvl;

  always @*
  begin
    st_next = st_reg;
    idx_next = idx_reg;
    code_next = diagnostic_code;
    entry_next = 1'b0;
    case (st_reg)
      ST_IDLE:
      begin
        st_next = ST_INIT;
        entry_next = 1'b1;
        code_next = `DIAG_INIT;
      end
      ST_INIT, ST_WAIT:
      begin
        if (param_bad)
        begin
          st_next = ST_ERR;
          code_next = `DIAG_PARAM;
        end
        else if (entry_reg && rst_lvl && !rst_rise)
        begin
          st_next = ST_ERR;
          code_next = (st_reg == ST_INIT) ? `DIAG_RESET_INIT : `DIAG_RESET_WAIT;
        end
        else if (rst_rise)
        begin
          st_next = ST_RUN;
          idx_next = 4'h0;
          code_next = `DIAG_FREE;
        end
      end
      ST_RUN:
      begin
        st_next = ST_ERR;
        if (param_bad)
          code_next = `DIAG_PARAM;
        else if (seq_bad)
          code_next = {`DIAG_SEQ_HIGH, bad_idx, sensor_b2_level, sensor_b1_level,
            sensor_a2_level, sensor_a1_level, `DIAG_SEQ_LOW};
        else if (over_dur)
          code_next = `DIAG_DURATION;
        else if (over_a)
          code_next = `DIAG_SKEW_A;
        else if (over_b)
          code_next = `DIAG_SKEW_B;
        else if (mut_now && !lamp_ok)
          code_next = `DIAG_LAMP;
        else
        begin
          st_next = ST_RUN;
          idx_next = nidx;
          code_next = state_code(nidx);
        end
      end
      ST_ERR:
        if (cause_clear)
        begin
          st_next = ST_WAIT;
          entry_next = 1'b1;
          code_next = `DIAG_WAIT_RESET;
        end
      default:
        st_next = ST_IDLE;
    endcase
    if (!activate)
    begin
      st_next = ST_IDLE;
      idx_next = 4'h0;
      code_next = `DIAG_IDLE;
      entry_next = 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= ST_IDLE;
      idx_reg <= 4'h0;
      entry_reg <= 1'b0;
      diagnostic_code <= `DIAG_IDLE;
      ready <= 1'b0;
      error <= 1'b0;
      guarded_release_out <= 1'b0;
      muting_active_out <= 1'b0;
    end
    else if (ce)
    begin
      st_reg <= st_next;
      idx_reg <= idx_next;
      entry_reg <= entry_next;
      diagnostic_code <= code_next;
      ready <= (st_next != ST_IDLE);
      error <= (st_next == ST_ERR);
      guarded_release_out <= (st_next == ST_RUN);
      muting_active_out <= (st_next == ST_RUN) && (idx_next != 4'h0);
    end
  end

  // apb slave, answers in the cycle after the access phase opens
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_reg <= `RST_CONTROL;
      pair_a_skew_limit <= `RST_PAIR_A_SKEW;
      pair_b_skew_limit <= `RST_PAIR_B_SKEW;
      muting_duration_limit <= `RST_DURATION;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready <= apb_access;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (apb_access)
      begin
        case (paddr)
          `OFS_CONTROL:
          begin
            if (wr)
              control_reg <= {31'h00000000, pwdata[`CTRL_ACTIVATE_BIT]};
            prdata <= control_reg;
          end
          `OFS_PAIR_A_SKEW:
          begin
            if (wr)
              pair_a_skew_limit <= pwdata;
            prdata <= pair_a_skew_limit;
          end
          `OFS_PAIR_B_SKEW:
          begin
            if (wr)
              pair_b_skew_limit <= pwdata;
            prdata <= pair_b_skew_limit;
          end
          `OFS_DURATION:
          begin
            if (wr)
              muting_duration_limit <= pwdata;
            prdata <= muting_duration_limit;
          end
          `OFS_STATUS:
            prdata <= {12'h000, ready, error, guarded_release_out, muting_active_out,
              diagnostic_code};
          `OFS_INPUTS:
            prdata <= {25'h0000000, lvl};
          default:
            pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // parallel_muting_error_handler

`default_nettype wire

// ---- muting_field_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module muting_field_model (
  input wire logic clk,
  input wire logic [6:0] want,
  output var logic [6:0] pins
);
  // {ack, lamp, permit, b2, b1, a2, a1}; contacts move only after an edge
  initial
    pins = 7'h70;
  always @(posedge clk)
    pins <= want;
endmodule // muting_field_model
`default_nettype wire

// ---- muting_checker_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module muting_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic pair_a_first_sensor,
  input wire logic pair_a_second_sensor,
  input wire logic pair_b_first_sensor,
  input wire logic pair_b_second_sensor,
  input wire logic lamp_health_in,
  input wire logic ready,
  input wire logic error,
  input wire logic guarded_release_out,
  input wire logic muting_active_out,
  input wire logic [15:0] diagnostic_code
);
  wire [3:0] snap = {pair_b_second_sensor, pair_b_first_sensor, pair_a_second_sensor,
    pair_a_first_sensor};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_error_outputs_off: assert property (error |-> ready && !guarded_release_out && !muting_active_out)
    else $error("outputs not safe in error");
  a_idle_all_off: assert property (diagnostic_code == 16'h0000 |-> !ready && !error &&
    !guarded_release_out && !muting_active_out)
    else $error("idle code with outputs set");
  a_error_class: assert property (error |-> diagnostic_code[15:12] == 4'hC)
    else $error("error code class wrong");
  a_seq_index: assert property (error && diagnostic_code[3:0] == 4'h4 |->
    diagnostic_code[11:8] <= 4'hC || diagnostic_code[11:8] == 4'hF)
    else $error("sequence index out of range");
  // the sampler latched the pins seen two edges before the edge where error is seen high; this compares those seen one edge before
  a_seq_snapshot: assert property ($rose(error) && diagnostic_code[3:0] == 4'h4 |->
    diagnostic_code[7:4] == $past(snap, 1))
    else $error("sensor snapshot wrong");
  a_code_held: assert property (error && $past(error) |-> $stable(diagnostic_code))
    else $error("error code changed");
  a_lamp_fault: assert property (ce && muting_active_out && !lamp_health_in |-> ##[1:3] error)
    else $error("lamp failure missed");
  a_err_exit: assert property ($fell(error) |-> diagnostic_code == 16'h8003 ||
    diagnostic_code == 16'h0000)
    else $error("error left without wait");
  a_release_after_ack: assert property ($rose(guarded_release_out) |->
    $past(diagnostic_code) == 16'h8003 || $past(diagnostic_code) == 16'h8001)
    else $error("release without acknowledge");
  c_error: cover property ($rose(error));
  c_muting: cover property ($rose(muting_active_out));
  c_exit: cover property ($fell(error));
endmodule // muting_checker
bind parallel_muting_error_handler muting_checker chk_u (.clk(clk), .rstn(rstn), .ce(ce),
  .pair_a_first_sensor(pair_a_first_sensor), .pair_a_second_sensor(pair_a_second_sensor),
  .pair_b_first_sensor(pair_b_first_sensor), .pair_b_second_sensor(pair_b_second_sensor),
  .lamp_health_in(lamp_health_in), .ready(ready), .error(error),
  .guarded_release_out(guarded_release_out), .muting_active_out(muting_active_out),
  .diagnostic_code(diagnostic_code));
`default_nettype wire

// ---- parallel_muting_error_handler_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "muting_defs.vh"
module parallel_muting_error_handler_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [6:0] want = 7'h70;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] pins;
  logic ready;
  logic error;
  logic rel;
  logic mut;
  logic [15:0] code;
  int err_total = 0;
  int comparisons = 0;
  wire [31:0] outs = {28'h0, error, ready, rel, mut};
  always #20 clk = ~clk;
  muting_field_model field_u (.clk(clk), .want(want), .pins(pins));
  parallel_muting_error_handler #(.MS_CYCLES(4)) dut_u (.clk(clk), .rstn(rstn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pair_a_first_sensor(pins[0]),
    .pair_a_second_sensor(pins[1]), .pair_b_first_sensor(pins[2]),
    .pair_b_second_sensor(pins[3]), .muting_permit(pins[4]), .lamp_health_in(pins[5]),
    .reset_in(pins[6]), .ready(ready), .error(error), .guarded_release_out(rel),
    .muting_active_out(mut), .diagnostic_code(code));
  task automatic complete_run;
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one idle edge after each transfer keeps psel from being written twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    cmp({31'h0, pready}, 32'h1);
    if (n >= 40)
      complete_run;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    cmp(q, exp);
    cmp({31'h0, e}, {31'h0, exp_err});
  endtask
  task automatic wait_code(input logic [15:0] c);
    int n;
    n = 0;
    while (code !== c && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    cmp({16'h0, code}, {16'h0, c});
    if (n >= 200)
      complete_run;
  endtask
  task automatic recover;
    want <= 7'h30;
    wait_code(`DIAG_WAIT_RESET);
    want <= 7'h70;
    wait_code(`DIAG_FREE);
    want <= 7'h30;
    @(posedge clk);
  endtask
  task automatic t_regs;
    rd(`OFS_STATUS, 32'h0, 1'b0);
    rd(`OFS_INPUTS, 32'h00000070, 1'b0);
    rd(`OFS_PAIR_A_SKEW, `RST_PAIR_A_SKEW, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
  endtask
  task automatic t_init_reset_high;
    wr(`OFS_CONTROL, 32'h1);
    wait_code(`DIAG_RESET_INIT);
    rd(`OFS_STATUS, 32'h000CC001, 1'b0);
    recover;
    cmp(outs, 32'h6);
  endtask
  task automatic t_seq_order;
    logic [6:0] s1 [2] = '{7'h31, 7'h34};
    logic [15:0] c1 [2] = '{16'h8011, 16'h8122};
    logic [15:0] c2 [2] = '{16'hC154, 16'hC754};
    for (int i = 0; i < 2; i++)
    begin
      want <= s1[i];
      wait_code(c1[i]);
      cmp(outs, 32'h7);
      want <= 7'h35;
      wait_code(c2[i]);
      cmp(outs, 32'hC);
      recover;
    end
  endtask
  task automatic t_no_permit;
    want <= 7'h21;
    wait_code(16'hCF14);
    recover;
  endtask
  task automatic t_skew;
    wr(`OFS_PAIR_A_SKEW, 32'h2);
    wr(`OFS_PAIR_B_SKEW, 32'h2);
    want <= 7'h31;
    wait_code(`DIAG_SKEW_A);
    recover;
    want <= 7'h33;
    wait_code(16'h8012);
    want <= 7'h37;
    wait_code(16'h8014);
    wait_code(`DIAG_SKEW_B);
    recover;
  endtask
  task automatic t_duration;
    wr(`OFS_DURATION, 32'h3);
    want <= 7'h33;
    wait_code(`DIAG_DURATION);
    recover;
    wr(`OFS_DURATION, `RST_DURATION);
  endtask
  task automatic t_lamp;
    want <= 7'h33;
    wait_code(16'h8012);
    want <= 7'h13;
    wait_code(`DIAG_LAMP);
    recover;
  endtask
  task automatic t_param;
    logic [7:0] a [4] = '{`OFS_PAIR_A_SKEW, `OFS_PAIR_A_SKEW, `OFS_PAIR_B_SKEW, `OFS_DURATION};
    logic [31:0] v [4] = '{32'h00000FA1, 32'hFFFFFFFF, 32'h00000FA1, 32'h000927C1};
    for (int i = 0; i < 4; i++)
    begin
      wr(a[i], v[i]);
      wait_code(`DIAG_PARAM);
      cmp(outs, 32'hC);
      if (i < 3)
      begin
        wr(a[i], `RST_PAIR_A_SKEW);
        recover;
      end
    end
  endtask
  task automatic t_deactivate;
    wr(`OFS_CONTROL, 32'h0);
    wait_code(`DIAG_IDLE);
    rd(`OFS_STATUS, 32'h0, 1'b0);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_init_reset_high;
    t_seq_order;
    t_no_permit;
    t_skew;
    t_duration;
    t_lamp;
    t_param;
    t_deactivate;
    complete_run;
  end
endmodule // parallel_muting_error_handler_tb_top
`default_nettype wire
